/* File: hw/sbt_pkg.sv */
/*
  Shared constants and types of the boundary-scan test port and its controller.
  Assumes nothing; imported whole by both ends.
*/
package sbt_pkg;
  // ----------------------------------------
  // Register widths and instruction codes
  // ----------------------------------------
  localparam int        IR_W      = 3;
  localparam int        ID_W      = 32;
  localparam int        BSR_W     = 107;
  localparam int        BSR_OE    = 47;           // Internal output-bus enable cell
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_IDCODE = 3'h1;
  localparam logic [2:0] IR_SAMPZ  = 3'h2;
  localparam logic [2:0] IR_SAMPLE = 3'h4;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPPAT = 2'h1;        // Fixed capture pattern 01
  // Identification fields; values are arbitrary, not a real part
  localparam logic [2:0]  ID_REV    = 3'h1;
  localparam logic [16:0] ID_DEV    = 17'h0_1234;
  localparam logic [10:0] ID_VENDOR = 11'h2a5;
  localparam logic [31:0] ID_WORD   = {ID_REV, ID_DEV, ID_VENDOR, 1'b1};
  // ----------------------------------------
  // Controller timing and commands
  // ----------------------------------------
  localparam int DATA_W        = 128;
  localparam int CLK_NS        = 4;
  localparam int TCK_CYCLE_NS  = 50;
  localparam int TCK_HALF      = (TCK_CYCLE_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int RESET_ONES    = 5;
  localparam logic [1:0] CMD_RESET = 2'h0;
  localparam logic [1:0] CMD_IR    = 2'h1;
  localparam logic [1:0] CMD_DR    = 2'h2;
  // ----------------------------------------
  // Test state machine
  // ----------------------------------------
  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SELDR, S_CAPDR, S_SHDR, S_EX1DR, S_PAUDR, S_EX2DR, S_UPDDR,
    S_SELIR, S_CAPIR, S_SHIR, S_EX1IR, S_PAUIR, S_EX2IR, S_UPDIR
  } sbt_state_t;
  typedef enum logic {H_IDLE, H_RUN} sbt_host_t;
endpackage

/* File: hw/sbt_link_if.sv */
/*
  Serial test link between controller and test port.
  Assumes the controller makes the test clock; a pull-up resolves an undriven select line.
*/
`timescale 1ns/10ps
interface sbt_link_if;
  logic tck;      // Test clock from controller
  logic tmsDrv;   // Mode select as driven
  logic tmsEn;    // Mode select driver enable
  logic tmsLine;  // Mode select at the pin
  logic tdi;      // Serial data toward the port
  logic tdoOut;   // Serial data from the port
  logic tdoOe;    // Serial output enable
  logic tdoLine;  // Serial output at the pin
  // Internal pull-up: a floating select reads high
  assign tmsLine = tmsEn ? tmsDrv : 1'b1;
  // No pull-up on the serial output: an undriven line shows a wrong value
  assign tdoLine = tdoOe ? tdoOut : ~tdoOut;
  modport dev  (input tck, tmsLine, tdi, output tdoOut, tdoOe);
  modport host (output tck, tmsDrv, tmsEn, tdi, input tdoLine);
endinterface // sbt_link_if

/* File: hw/sbt_tap.sv */
/*
  Boundary-scan test port of the memory: state machine, instruction,
  bypass, identification and boundary registers, all on the test clock.
  Assumes the memory ring is sampled asynchronously and that reset is
  a power-up pulse seen on the test clock.
*/
`timescale 1ns/10ps
module sbt_tap
  import sbt_pkg::*;
(
  sbt_link_if.dev              link,       // Serial pins
  input  wire logic            reset,      // Power-up reset, sync to test clock
  input  wire logic            ce,         // Freezes all state while low
  input  wire logic [BSR_W-1:0] ringIn,    // Memory pin ring values
  output logic [BSR_W-1:0]     ringOut,    // Latched preload values
  output logic                 extestOn,   // Preload values drive pins
  output logic                 qBusOff     // Memory output bus to high-Z
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  sbt_state_t       state_q;               // Test state
  sbt_state_t       state_d;               // Next test state
  logic [IR_W-1:0]  irShift_q;             // Instruction shift stage
  logic [IR_W-1:0]  ir_q;                  // Active instruction
  logic             bypass_q;              // Bypass cell
  logic [ID_W-1:0]  idShift_q;             // Identification shift stage
  logic [BSR_W-1:0] bsShift_q;             // Boundary shift stage
  logic [BSR_W-1:0] bsUpd_q;               // Boundary update latches
  logic [BSR_W-1:0] ringS1_q;              // Ring synchroniser stage 1
  logic [BSR_W-1:0] ringS2_q;              // Ring synchroniser stage 2
  logic [BSR_W-1:0] ringS3_q;              // Ring synchroniser stage 3
  logic [BSR_W-1:0] ringSt_q;              // Ring value once stable
  logic             tdo_q;                 // Serial output, falling edge
  logic             tdoOe_q;               // Serial enable, falling edge
  logic             ext_q;                 // Extest active
  logic             off_q;                 // Output bus off
  logic             tms;                   // Sampled mode select
  assign tms = link.tmsLine;
  // ----------------------------------------
  // Decodes
  // ----------------------------------------
  wire inTlr   = (state_q == S_TLR);
  wire capDr   = (state_q == S_CAPDR);
  wire shDr    = (state_q == S_SHDR);
  wire updDr   = (state_q == S_UPDDR);
  wire capIr   = (state_q == S_CAPIR);
  wire shIr    = (state_q == S_SHIR);
  wire updIr   = (state_q == S_UPDIR);
  // Boundary register serves three instructions
  wire selBsr  = (ir_q == IR_EXTEST) || (ir_q == IR_SAMPZ) || (ir_q == IR_SAMPLE);
  wire selId   = (ir_q == IR_IDCODE);
  // Bypass and reserved codes fall back to the one-bit path
  wire selByp  = !selBsr && !selId;
  // Serial output picks one register's least significant bit
  wire drBit   = selBsr ? bsShift_q[0] : selId ? idShift_q[0] : bypass_q;
  wire outBit  = shIr ? irShift_q[0] : drBit;
  // Values the flops will hold after this edge
  wire [IR_W-1:0] irNext = (inTlr || reset) ? IR_IDCODE : updIr ? irShift_q : ir_q;
  wire            oeNext = (inTlr || reset) ? 1'b1 : (updDr && selBsr) ? bsShift_q[BSR_OE] : bsUpd_q[BSR_OE];
  // Captured ring: the enable cell is internal, so it reflects its latch
  wire [BSR_W-1:0] ringCap;
  assign ringCap = {ringSt_q[BSR_W-1:BSR_OE+1], bsUpd_q[BSR_OE], ringSt_q[BSR_OE-1:0]};
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Standard sequence; five highs from anywhere land in reset
  always_comb begin
    case (state_q)
      S_TLR:   state_d = tms ? S_TLR   : S_RTI;
      S_RTI:   state_d = tms ? S_SELDR : S_RTI;
      S_SELDR: state_d = tms ? S_SELIR : S_CAPDR;
      S_CAPDR: state_d = tms ? S_EX1DR : S_SHDR;
      S_SHDR:  state_d = tms ? S_EX1DR : S_SHDR;
      S_EX1DR: state_d = tms ? S_UPDDR : S_PAUDR;
      S_PAUDR: state_d = tms ? S_EX2DR : S_PAUDR;
      S_EX2DR: state_d = tms ? S_UPDDR : S_SHDR;
      S_UPDDR: state_d = tms ? S_SELDR : S_RTI;
      S_SELIR: state_d = tms ? S_TLR   : S_CAPIR;
      S_CAPIR: state_d = tms ? S_EX1IR : S_SHIR;
      S_SHIR:  state_d = tms ? S_EX1IR : S_SHIR;
      S_EX1IR: state_d = tms ? S_UPDIR : S_PAUIR;
      S_PAUIR: state_d = tms ? S_EX2IR : S_PAUIR;
      S_EX2IR: state_d = tms ? S_UPDIR : S_SHIR;
      S_UPDIR: state_d = tms ? S_SELDR : S_RTI;
      default: state_d = S_TLR;
    endcase
  end
  // ----------------------------------------
  // Rising-edge logic
  // ----------------------------------------
  // State advances on the rising edge; power-up reset forces reset state
  always_ff @(posedge link.tck) begin
    if (reset) begin
      state_q <= S_TLR;
    end else if (ce) begin
      state_q <= state_d;
    end
  end
  // Instruction register: capture 01, shift in at MSB, act at update; reset state loads IDCODE
  always_ff @(posedge link.tck) begin
    if (reset) begin
      irShift_q <= IR_IDCODE;
      ir_q      <= IR_IDCODE;
    end else if (ce) begin
      ir_q <= irNext;
      if (capIr) begin
        irShift_q <= {ir_q[IR_W-1], IR_CAPPAT};
      end else if (shIr) begin
        irShift_q <= {link.tdi, irShift_q[IR_W-1:1]};
      end
    end
  end
  // Bypass cell: zero on capture, follows input while shifting
  always_ff @(posedge link.tck) begin
    if (reset) begin
      bypass_q <= 1'b0;
    end else if (ce && selByp) begin
      if (capDr) begin
        bypass_q <= 1'b0;
      end else if (shDr) begin
        bypass_q <= link.tdi;
      end
    end
  end
  // Identification word: hard-wired value loaded on capture
  always_ff @(posedge link.tck) begin
    if (reset) begin
      idShift_q <= ID_WORD;
    end else if (ce && selId) begin
      if (capDr) begin
        idShift_q <= ID_WORD;
      end else if (shDr) begin
        idShift_q <= {link.tdi, idShift_q[ID_W-1:1]};
      end
    end
  end
  // Boundary chain: capture ring, shift, latch at update
  always_ff @(posedge link.tck) begin
    if (reset) begin
      bsShift_q <= '0;
    end else if (ce && selBsr) begin
      if (capDr) begin
        bsShift_q <= ringCap;
      end else if (shDr) begin
        bsShift_q <= {link.tdi, bsShift_q[BSR_W-1:1]};
      end
    end
  end
  // Update latches; the enable cell presets high on any test reset
  always_ff @(posedge link.tck) begin
    if (reset) begin
      bsUpd_q          <= '0;
      bsUpd_q[BSR_OE]  <= 1'b1;
    end else if (ce) begin
      if (updDr && selBsr) begin
        bsUpd_q <= bsShift_q;
      end
      bsUpd_q[BSR_OE] <= oeNext;
    end
  end
  // Ring crosses from the memory clock: three stages, change once 2 and 3 agree.
  // Capture near a ring transition may still see an old value; that is expected.
  always_ff @(posedge link.tck) begin
    if (reset) begin
      ringS1_q <= '0;
      ringS2_q <= '0;
      ringS3_q <= '0;
      ringSt_q <= '0;
    end else if (ce) begin
      ringS1_q <= ringIn;
      ringS2_q <= ringS1_q;
      ringS3_q <= ringS2_q;
      ringSt_q <= (ringS2_q & ringS3_q) | (ringSt_q & (ringS2_q | ringS3_q));
    end
  end
  // Memory-facing controls; test reset returns both to normal operation
  always_ff @(posedge link.tck) begin
    if (reset) begin
      ext_q <= 1'b0;
      off_q <= 1'b0;
    end else if (ce) begin
      ext_q <= (irNext == IR_EXTEST);
      // Sample-Z holds the bus off until a new instruction is updated
      off_q <= (irNext == IR_SAMPZ) || ((irNext == IR_EXTEST) && !oeNext);
    end
  end
  // ----------------------------------------
  // Falling-edge output
  // ----------------------------------------
  // Output changes only on the falling edge, enabled only while shifting
  always_ff @(negedge link.tck) begin
    if (reset) begin
      tdo_q   <= 1'b0;
      tdoOe_q <= 1'b0;
    end else if (ce) begin
      tdo_q   <= outBit;
      tdoOe_q <= shIr || shDr;
    end
  end
  assign link.tdoOut = tdo_q;
  assign link.tdoOe  = tdoOe_q;
  assign ringOut     = bsUpd_q;
  assign extestOn    = ext_q;
  assign qBusOff     = off_q;
endmodule // sbt_tap

/* File: hw/sbt_ctl.sv */
/*
  Scan controller: makes the test clock by division and walks the
  port through reset, instruction and data scans.
  Assumes commands arrive on clk and the port follows the standard sequence.
*/
`timescale 1ns/10ps
module sbt_ctl
  import sbt_pkg::*;
(
  input  wire logic              clk,       // System clock
  input  wire logic              reset,     // Synchronous, active high
  input  wire logic              ce,        // Freezes all state while low
  sbt_link_if.host               link,      // Serial pins
  input  wire logic              cmdValid,  // Command offered
  input  wire logic [1:0]        cmdKind,   // Reset, IR or DR scan
  input  wire logic [7:0]        cmdLen,    // Bits to shift
  input  wire logic [DATA_W-1:0] cmdData,   // Bits, LSB first
  output logic                   cmdReady,  // Idle, accepts a command
  output logic                   cmdRefused,// Pulse: reserved code refused
  output logic                   rspValid,  // Pulse: scan done
  output logic [DATA_W-1:0]      rspData    // Bits seen, LSB first
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  sbt_host_t         st_q;       // Busy or idle
  logic [7:0]        div_q;      // Half-period counter
  logic              tck_q;      // Test clock out
  logic [7:0]        step_q;     // Current step
  logic [7:0]        pre_q;      // Steps before shifting
  logic [5:0]        preTms_q;   // Select values of those steps
  logic [7:0]        len_q;      // Shift steps
  logic [7:0]        tot_q;      // All steps
  logic [DATA_W-1:0] data_q;     // Outgoing bits
  logic [DATA_W-1:0] rx_q;       // Incoming bits
  logic              tms_q;      // Mode select out
  logic              tdi_q;      // Data out
  logic [2:0]        tdoS_q;     // Serial input synchroniser
  logic              tdoSt_q;    // Serial input once stable
  logic              ready_q;
  logic              ref_q;
  logic              rv_q;
  // ----------------------------------------
  // Step decoding
  // ----------------------------------------
  // Returns {inShift, tms, tdi} for a step index
  // Every register it reads is an argument, so the wires below follow all of them
  function automatic logic [2:0] stepOut(input logic [7:0]        idx,
                                         input logic [7:0]        pre,
                                         input logic [5:0]        pt,
                                         input logic [7:0]        len,
                                         input logic [DATA_W-1:0] data);
    logic [7:0] j;
    logic       sh;
    j  = idx - pre;
    sh = (idx >= pre) && (j < len);
    if (idx < pre) begin
      stepOut = {1'b0, pt[idx[2:0]], 1'b1};
    end else if (sh) begin
      stepOut = {1'b1, (j == len - 8'h01), data[j[6:0]]};
    end else begin
      stepOut = {1'b0, (j == len), 1'b1};  // Exit then update, then idle
    end
  endfunction
  wire [7:0] nxtIdx  = step_q + 8'h01;
  wire [2:0] curOut  = stepOut(step_q, pre_q, preTms_q, len_q, data_q);
  wire [2:0] nxtOut  = stepOut(nxtIdx, pre_q, preTms_q, len_q, data_q);
  wire       halfEnd = (div_q == 8'(TCK_HALF - 1));
  wire       rise    = (st_q == H_RUN) && halfEnd && !tck_q;
  wire       fall    = (st_q == H_RUN) && halfEnd && tck_q;
  // Reserved codes are 011, 101, 110; a controller must never load them
  wire [2:0] irc     = cmdData[2:0];
  wire       resv    = (irc == 3'h3) || (irc == 3'h5) || (irc == 3'h6);
  wire       take    = ready_q && cmdValid;
  wire       bad     = take && (cmdKind == CMD_IR) && resv;
  wire       isRst   = (cmdKind == CMD_RESET);
  // Run-idle to shift: IR needs 1,1,0,0 and DR 1,0,0; reset is five ones then 0
  wire [5:0] pTms    = isRst ? 6'h1f : (cmdKind == CMD_IR) ? 6'h03 : 6'h01;
  wire [7:0] pN      = isRst ? 8'(RESET_ONES + 1) : (cmdKind == CMD_IR) ? 8'h04 : 8'h03;
  wire [7:0] lN      = isRst ? 8'h00 : cmdLen;
  wire [7:0] tN      = isRst ? pN : pN + lN + 8'h02;
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Accept, then step once per test clock; outputs change while clock is low
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= H_IDLE; div_q <= '0; tck_q <= 1'b0; step_q <= '0;
      pre_q <= '0; preTms_q <= '0; len_q <= '0; tot_q <= '0; data_q <= '0;
      tms_q <= 1'b1; tdi_q <= 1'b1; ready_q <= 1'b0; ref_q <= 1'b0; rv_q <= 1'b0;
    end else if (ce) begin
      ref_q <= bad;
      rv_q  <= 1'b0;
      if (st_q == H_IDLE) begin
        ready_q <= !take;
        if (take && !bad) begin
          st_q <= H_RUN; div_q <= '0; step_q <= '0; pre_q <= pN;
          preTms_q <= pTms; len_q <= lN; tot_q <= tN; data_q <= cmdData;
          tms_q <= pTms[0];
          tdi_q <= 1'b1;
        end else if (bad) begin
          ready_q <= 1'b1;
        end
      end else begin
        div_q <= halfEnd ? 8'h00 : div_q + 8'h01;
        if (rise) begin
          tck_q <= 1'b1;
        end else if (fall) begin
          tck_q  <= 1'b0;
          step_q <= nxtIdx;
          tms_q  <= nxtOut[1];
          tdi_q  <= nxtOut[0];
          if (nxtIdx == tot_q) begin
            st_q <= H_IDLE; ready_q <= 1'b1; rv_q <= 1'b1;
          end
        end
      end
    end
  end
  // Serial input: three stages, change once the last two agree
  always_ff @(posedge clk) begin
    if (reset) begin
      tdoS_q <= '0; tdoSt_q <= 1'b1; rx_q <= '0;
    end else if (ce) begin
      tdoS_q <= {tdoS_q[1:0], link.tdoLine};
      if (tdoS_q[1] == tdoS_q[2]) begin
        tdoSt_q <= tdoS_q[2];
      end
      // Port drove its bit on the prior falling edge; take it at the rise
      if (rise && curOut[2]) begin
        rx_q[7'(step_q - pre_q)] <= tdoSt_q;
      end
    end
  end
  // Clock rests low between scans so the port stays frozen
  assign link.tck    = tck_q;
  assign link.tmsDrv = tms_q;
  assign link.tmsEn  = 1'b1;
  assign link.tdi    = tdi_q;
  assign cmdReady    = ready_q;
  assign cmdRefused  = ref_q;
  assign rspValid    = rv_q;
  assign rspData     = rx_q;
endmodule // sbt_ctl

/* File: bench/sbt_link_monitor.sv */
/*
  Link checker: shadows the test state machine and instruction on the test clock.
  Assumes only the plain link signals and the port's own reset.
*/
`timescale 1ns/10ps
module sbt_link_monitor
  import sbt_pkg::*;
(
  input wire logic tck,
  input wire logic reset,
  input wire logic tmsLine,
  input wire logic tdi,
  input wire logic tdoOut,
  input wire logic tdoOe
);
  // ----------------------------------------
  // Shadow model
  // ----------------------------------------
  sbt_state_t state_q, state_d;  // Expected port state
  logic [2:0] ir_q, irShift_q;   // Expected instruction and its shifter
  logic [1:0] tdoRise_q;         // Output pair seen at the rise
  logic       rstRise_q;         // Reset seen at the rise
  logic       inShift, capDr;    // Decoded state flags
  assign inShift = (state_q == S_SHIR) || (state_q == S_SHDR);
  assign capDr   = (state_q == S_CAPDR) && !tmsLine;
  // Standard sequence; a high select always heads toward reset
  always_comb begin
    case (state_q)
      S_TLR:   state_d = tmsLine ? S_TLR   : S_RTI;
      S_RTI:   state_d = tmsLine ? S_SELDR : S_RTI;
      S_SELDR: state_d = tmsLine ? S_SELIR : S_CAPDR;
      S_CAPDR: state_d = tmsLine ? S_EX1DR : S_SHDR;
      S_SHDR:  state_d = tmsLine ? S_EX1DR : S_SHDR;
      S_EX1DR: state_d = tmsLine ? S_UPDDR : S_PAUDR;
      S_PAUDR: state_d = tmsLine ? S_EX2DR : S_PAUDR;
      S_EX2DR: state_d = tmsLine ? S_UPDDR : S_SHDR;
      S_SELIR: state_d = tmsLine ? S_TLR   : S_CAPIR;
      S_CAPIR: state_d = tmsLine ? S_EX1IR : S_SHIR;
      S_SHIR:  state_d = tmsLine ? S_EX1IR : S_SHIR;
      S_EX1IR: state_d = tmsLine ? S_UPDIR : S_PAUIR;
      S_PAUIR: state_d = tmsLine ? S_EX2IR : S_PAUIR;
      S_EX2IR: state_d = tmsLine ? S_UPDIR : S_SHIR;
      default: state_d = tmsLine ? S_SELDR : S_RTI;
    endcase
  end
  // Shadow registers; the instruction only changes at update or reset
  always_ff @(posedge tck) begin
    tdoRise_q <= {tdoOe, tdoOut};
    rstRise_q <= reset;
    state_q   <= reset ? S_TLR : state_d;
    if (reset || state_q == S_TLR) begin
      ir_q <= IR_IDCODE;
    end else if (state_q == S_UPDIR) begin
      ir_q <= irShift_q;
    end
    if (state_q == S_CAPIR) begin
      irShift_q <= {ir_q[2], IR_CAPPAT};
    end else if (state_q == S_SHIR) begin
      irShift_q <= {tdi, irShift_q[2:1]};
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  fall_drive_a: assert property (@(negedge tck) disable iff (reset)
    !rstRise_q |-> {tdoOe, tdoOut} == tdoRise_q) else $error("serial output moved on a rising edge");
  oe_shift_a: assert property (@(posedge tck) disable iff (reset)
    tdoOe == inShift) else $error("serial output enable outside shift states");
  cap_ir_a: assert property (@(posedge tck) disable iff (reset)
    (state_q == S_CAPIR && !tmsLine) |=> tdoOut ##1 ($past(tmsLine) || !tdoOut))
    else $error("instruction capture pattern wrong");
  ir_len_a: assert property (@(posedge tck) disable iff (reset)
    (state_q == S_SHIR && $past(state_q) == S_SHIR && $past(state_q, 2) == S_SHIR && $past(state_q, 3) == S_SHIR)
    |-> tdoOut == $past(tdi, 3)) else $error("instruction path not three bits");
  id_first_a: assert property (@(posedge tck) disable iff (reset)
    (capDr && ir_q == IR_IDCODE) |=> tdoOut == ID_WORD[0]) else $error("identification bit 0 wrong");
  id_second_a: assert property (@(posedge tck) disable iff (reset)
    (capDr && ir_q == IR_IDCODE) ##1 (state_q == S_SHDR && !tmsLine) |=> tdoOut == ID_WORD[1])
    else $error("identification bit 1 wrong");
  byp_clear_a: assert property (@(posedge tck) disable iff (reset)
    (capDr && ir_q == IR_BYPASS) |=> !tdoOut) else $error("bypass not cleared at capture");
  byp_path_a: assert property (@(posedge tck) disable iff (reset)
    (state_q == S_SHDR && $past(state_q) == S_SHDR && ir_q == IR_BYPASS) |-> tdoOut == $past(tdi))
    else $error("bypass path not one stage");
endmodule // sbt_link_monitor

/* File: bench/sram_boundary_scan_tap_tb_top.sv */
/*
  Testbench: controller and test port joined by the link, driven by scan commands.
  Assumes the controller makes the test clock from clk.
*/
`timescale 1ns/10ps
module sram_boundary_scan_tap_tb_top
  import sbt_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic                clk, rst, tapReset, refused;
  logic                cmdValid, cmdReady, cmdRefused, rspValid;
  logic [1:0]          cmdKind;
  logic [7:0]          cmdLen;
  logic [DATA_W-1:0]   cmdData, rspData;
  logic [BSR_W-1:0]    ringOut;
  logic                extestOn, qBusOff;
  int                  miscompares, checks_done;
  // Ring pattern is static, so capture never races the slow test clock
  localparam logic [BSR_W-1:0]  RING_PAT = {11'h5a3, 32'h9c3e_71b4, 32'h0f1e_2d3c, 32'h4b5a_6978};
  localparam logic [BSR_W-1:0]  KEEP     = ~(107'h1 << BSR_OE);  // Internal cell is not a ring pin
  localparam logic [DATA_W-1:0] PAT      = {32'h1357_9bdf, 32'h2468_ace0, 32'hf0e1_d2c3, 32'hb4a5_9687};
  sbt_link_if link ();
  sbt_tap i_sbt_tap (.link(link.dev), .reset(tapReset), .ce(1'b1), .ringIn(RING_PAT), .ringOut(ringOut),
                     .extestOn(extestOn), .qBusOff(qBusOff));
  sbt_ctl i_sbt_ctl (.clk(clk), .reset(rst), .ce(1'b1), .link(link.host), .cmdValid(cmdValid),
                     .cmdKind(cmdKind), .cmdLen(cmdLen), .cmdData(cmdData), .cmdReady(cmdReady),
                     .cmdRefused(cmdRefused), .rspValid(rspValid), .rspData(rspData));
  sbt_link_monitor i_sbt_link_monitor (.tck(link.tck), .reset(tapReset), .tmsLine(link.tmsLine),
                                       .tdi(link.tdi), .tdoOut(link.tdoOut), .tdoOe(link.tdoOe));
  always #2 clk = ~clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input bit ok, input string what);
    checks_done++;
    if (!ok) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One command, offered on a falling edge; waits are bounded
  task automatic run_cmd(input logic [1:0] kind, input logic [7:0] len, input logic [DATA_W-1:0] data);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000) begin
      miscompares++;
      $display("mismatch at %0t: controller never ready", $time);
      close_out();
    end
    cmdKind = kind;
    cmdLen = len;
    cmdData = data;
    cmdValid = 1'b1;
    @(negedge clk);
    cmdValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && cmdRefused !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    refused = cmdRefused;
    if (n >= 5000) begin
      miscompares++;
      $display("mismatch at %0t: command timed out", $time);
      close_out();
    end
    // Let an edge pass so a following command never re-raises valid in this step
    @(negedge clk);
  endtask
  // Bypass holds one stage: each bit comes out one step late, a zero first
  task automatic byp_scan();
    run_cmd(CMD_DR, 8'h08, DATA_W'(8'ha5));
    chk(rspData[7:0] === {7'h25, 1'b0}, "bypass path");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power();
    run_cmd(CMD_RESET, 8'h00, '0);
    tapReset = 1'b0;
    @(negedge clk);
    chk(link.tdoOe === 1'b0 && link.tdoLine === 1'b1, "output not off after reset");
    chk(extestOn === 1'b0 && qBusOff === 1'b0, "memory path disturbed by reset");
    chk(link.tck === 1'b0, "test clock not resting low");
    run_cmd(CMD_RESET, 8'h00, '0);
    $display("test power done");
  endtask
  task automatic t_idcode();
    run_cmd(CMD_DR, 8'h20, '0);
    chk(rspData[31:0] === ID_WORD, "identification word");
    $display("test idcode done");
  endtask
  task automatic t_bypass();
    run_cmd(CMD_IR, 8'h06, DATA_W'(6'h3f));
    chk(rspData[1:0] === IR_CAPPAT && rspData[5:3] === IR_BYPASS, "instruction capture");
    byp_scan();
    $display("test bypass done");
  endtask
  task automatic t_reserved();
    logic [2:0] rsv [3];
    rsv = '{3'h3, 3'h5, 3'h6};
    foreach (rsv[i]) begin
      run_cmd(CMD_IR, 8'h03, DATA_W'(rsv[i]));
      chk(refused === 1'b1, "reserved code accepted");
    end
    byp_scan();
    run_cmd(CMD_RESET, 8'h00, '0);
    run_cmd(CMD_DR, 8'h20, '0);
    chk(rspData[31:0] === ID_WORD, "reset did not restore identification");
    $display("test reserved done");
  endtask
  // 110 bits through a 107-bit chain: the first three sent come back last
  task automatic t_boundary();
    run_cmd(CMD_IR, 8'h03, DATA_W'(IR_SAMPLE));
    run_cmd(CMD_DR, 8'h6e, PAT);
    chk((rspData[BSR_W-1:0] & KEEP) === (RING_PAT & KEEP), "ring capture");
    chk(rspData[109:107] === PAT[2:0], "chain length");
    chk(ringOut === PAT[109:3], "preload");
    run_cmd(CMD_IR, 8'h03, DATA_W'(IR_SAMPZ));
    chk(qBusOff === 1'b1 && extestOn === 1'b0, "output bus not off");
    run_cmd(CMD_IR, 8'h03, DATA_W'(IR_EXTEST));
    chk(extestOn === 1'b1 && qBusOff === ~PAT[BSR_OE + 3], "output cell");
    run_cmd(CMD_DR, 8'h6e, ~PAT);
    chk(qBusOff === ~(~PAT[BSR_OE + 3]) && ringOut === ~PAT[109:3], "output cell enable");
    run_cmd(CMD_IR, 8'h03, DATA_W'(IR_IDCODE));
    chk(extestOn === 1'b0 && qBusOff === 1'b0, "output bus not released");
    $display("test boundary done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    tapReset = 1'b1;
    refused = 1'b0;
    cmdValid = 1'b0;
    cmdKind = CMD_RESET;
    cmdLen = 8'h00;
    cmdData = '0;
    miscompares = 0;
    checks_done = 0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_power();
    t_idcode();
    t_bypass();
    t_reserved();
    t_boundary();
    close_out();
  end
endmodule // sram_boundary_scan_tap_tb_top
